// >>> verilog/clkdist_pkg.sv
package clkdist_pkg;

	// ----------------------------------------------------------------
	// Structure
	// ----------------------------------------------------------------
	localparam int N_SRC   = 7;   // Primary clock sources
	localparam int N_FAB   = 8;   // Extra clocks on the routing fabric
	localparam int N_DIG   = 8;   // Digital dividers
	localparam int N_ANA   = 4;   // Analog dividers
	localparam int N_DIV   = 12;  // All general dividers
	localparam int N_MUX   = 8;   // Inputs of each divider multiplexer
	localparam int RATIO_W = 16;
	localparam int SEL_W   = 3;
	localparam int SKEW_W  = 4;
	localparam int FAB_W   = 3;

	// Source numbering on the divider multiplexers
	localparam logic [2:0] SRC_INTERNAL_MAIN_OSCILLATOR = 3'h0;
	localparam logic [2:0] SRC_XTAL                     = 3'h1;
	localparam logic [2:0] SRC_ROUTED                   = 3'h2;
	localparam logic [2:0] SRC_PLL                      = 3'h3;
	localparam logic [2:0] SRC_DBL                      = 3'h4;
	localparam logic [2:0] SRC_LOW                      = 3'h5;
	localparam logic [2:0] SRC_WATCH                    = 3'h6;
	localparam logic [2:0] MUX_FABRIC                   = 3'h7;

	// ----------------------------------------------------------------
	// Register map (byte addresses) and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_BUS    = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_USB    = 8'h08;
	localparam logic [7:0] OFF_DIV0   = 8'h10;
	localparam logic [7:0] OFF_LAST   = 8'h3c;

	localparam int DIV_RATIO_LSB = 0;
	localparam int DIV_SEL_LSB   = 16;
	localparam int DIV_EN_BIT    = 19;
	localparam int DIV_FAB_LSB   = 20;
	localparam int DIV_SKEW_LSB  = 24;
	localparam int DIV_OUT_BIT   = 31;
	localparam int DIV_CFG_W     = 28;

	localparam int STAT_BUS_BIT  = 8;
	localparam int STAT_MULT_BIT = 9;

	localparam int USB_DBL_BIT   = 0;
	localparam int USB_DIN_LSB   = 1;
	localparam int USB_ALIVE_BIT = 8;

	localparam logic [1:0] DIN_INTERNAL_MAIN_OSCILLATOR = 2'h0;
	localparam logic [1:0] DIN_FABRIC                   = 2'h1;
	localparam logic [1:0] DIN_XTAL                     = 2'h2;

	// Reset values
	localparam logic [15:0] BUS_RATIO_RST = 16'h0002;
	localparam logic [27:0] DIV_CFG_RST   = 28'h0000002;
	localparam logic [2:0]  USB_CFG_RST   = 3'h1;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ      = 40;
	localparam int USB_MHZ      = 48;
	localparam int DBL_IN_MHZ   = 24;
	localparam int USB_ALIVE_NS = 1000;
	localparam int USB_ALIVE_CYC = USB_ALIVE_NS * CLK_MHZ / 1000;
	localparam int MEAS_CYC     = 256;
	localparam int MEAS_W       = 8;

endpackage : clkdist_pkg

// >>> verilog/clk_divider.sv
`timescale 1ns/1ps

module clk_divider #(
	parameter int RATIO_W  = 16,
	parameter int SEL_W    = 3,
	parameter int SKEW_W   = 4,
	parameter bit HAS_SKEW = 1'b0
) (
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic [2**SEL_W-1:0]   src_edge,
	input  wire logic [RATIO_W-1:0]    ratio,
	input  wire logic [SEL_W-1:0]      sel,
	input  wire logic                  en,
	input  wire logic [SKEW_W-1:0]     skew,
	output logic                       clk_out,
	output logic                       tick
);

	// ----------------------------------------------------------------
	// Active settings, counter and output phase
	// ----------------------------------------------------------------
	logic [RATIO_W-1:0]     act_ratio, next_act_ratio;
	logic [SEL_W-1:0]       act_sel, next_act_sel;
	logic [SKEW_W-1:0]      act_skew, next_act_skew;
	logic                   act_en, next_act_en;
	logic [RATIO_W-1:0]     cnt, next_cnt;
	logic                   raw, next_raw;
	logic [2**SKEW_W-1:0]   dly, next_dly;
	logic                   next_out;
	logic [RATIO_W-1:0]     eff_ratio;
	logic [RATIO_W:0]       hi_sum;
	logic                   edge_in;
	logic                   wrap;

	// Settings are only picked up at a period boundary or while
	// stopped, so a ratio or enable reprogram never cuts a phase short
	always_comb begin
		eff_ratio = (ratio < RATIO_W'(2)) ? RATIO_W'(2) : ratio;
		hi_sum = {1'b0, act_ratio} + {{RATIO_W{1'b0}}, 1'b1};
		edge_in = src_edge[act_sel];
		wrap = edge_in && (cnt == act_ratio - RATIO_W'(1));
		next_act_ratio = act_ratio;
		next_act_sel = act_sel;
		next_act_skew = act_skew;
		next_act_en = act_en;
		next_cnt = cnt;
		next_raw = raw;
		tick = act_en && wrap;
		if (!act_en || wrap) begin
			next_act_ratio = eff_ratio;
			next_act_sel = sel;
			next_act_skew = skew;
			next_act_en = en;
			next_cnt = act_en ? '0 : eff_ratio - RATIO_W'(1);
			next_raw = act_en && en;
		end else if (edge_in) begin
			next_cnt = cnt + RATIO_W'(1);
			// High for ceil(N/2) input edges, low for the rest
			next_raw = next_cnt < hi_sum[RATIO_W:1];
		end
		next_dly = {dly[2**SKEW_W-2:0], raw};
		next_out = HAS_SKEW ? dly[act_skew] : raw;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			act_ratio <= RATIO_W'(2);
			act_sel <= '0;
			act_skew <= '0;
			act_en <= 1'b0;
			cnt <= '0;
			raw <= 1'b0;
			dly <= '0;
			clk_out <= 1'b0;
		end else begin
			act_ratio <= next_act_ratio;
			act_sel <= next_act_sel;
			act_skew <= next_act_skew;
			act_en <= next_act_en;
			cnt <= next_cnt;
			raw <= next_raw;
			dly <= next_dly;
			clk_out <= next_out;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_wrap;
		act_en && wrap && en;
	endsequence

	a_ratio_floor: assert property (@(posedge hclk) disable iff (!hresetn)
		act_ratio >= RATIO_W'(2))
		else $error("divider ratio below two");

	a_load_boundary: assert property (@(posedge hclk) disable iff (!hresetn)
		(act_en && !wrap) |=> $stable(act_ratio) && $stable(act_sel))
		else $error("divider setting changed mid period");

	a_wrap_high: assert property (@(posedge hclk) disable iff (!hresetn)
		s_wrap |=> raw && (cnt == '0))
		else $error("divider period did not start high");

	a_idle_low: assert property (@(posedge hclk) disable iff (!hresetn)
		!act_en |=> !raw)
		else $error("stopped divider output not low");

endmodule : clk_divider

// >>> verilog/usb_clk_source.sv
`timescale 1ns/1ps

module usb_clk_source (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       cfg_use_doubler,
	input  wire logic [1:0] cfg_dbl_src,
	input  wire logic       usb_edge,
	output logic            use_doubler,
	output logic [1:0]      doubler_src,
	output logic            alive
);

	// ----------------------------------------------------------------
	// Source steering and activity watch
	// ----------------------------------------------------------------
	localparam logic [7:0] ALIVE_LOAD = 8'(clkdist_pkg::USB_ALIVE_CYC);

	logic [7:0] watch, next_watch;
	logic       next_alive;
	logic [1:0] next_src;

	// Only the doubler's three legal inputs pass; a bad code keeps
	// the oscillator so the 48 MHz domain never loses its source
	always_comb begin
		next_src = clkdist_pkg::DIN_INTERNAL_MAIN_OSCILLATOR;
		if (cfg_dbl_src == clkdist_pkg::DIN_FABRIC ||
			cfg_dbl_src == clkdist_pkg::DIN_XTAL) begin
			next_src = cfg_dbl_src;
		end
		next_watch = usb_edge ? ALIVE_LOAD :
			(watch != 8'h00 ? watch - 8'h01 : 8'h00);
		next_alive = next_watch != 8'h00;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			use_doubler <= 1'b1;
			doubler_src <= clkdist_pkg::DIN_INTERNAL_MAIN_OSCILLATOR;
			watch <= 8'h00;
			alive <= 1'b0;
		end else begin
			use_doubler <= cfg_use_doubler;
			doubler_src <= next_src;
			watch <= next_watch;
			alive <= next_alive;
		end
	end

	a_usb_alive: assert property (@(posedge hclk) disable iff (!hresetn)
		usb_edge |=> alive && (watch == ALIVE_LOAD))
		else $error("usb clock activity not flagged");

endmodule : usb_clk_source

// >>> verilog/clock_distribution.sv
`timescale 1ns/1ps

module clock_distribution (
	input  wire logic                       hclk,
	input  wire logic                       hresetn,
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic                            hreadyout,
	output logic                            hresp,
	output logic [31:0]                     hrdata,
	input  wire logic [clkdist_pkg::N_SRC-1:0] src_clk,
	input  wire logic [clkdist_pkg::N_FAB-1:0] fabric_clk,
	input  wire logic                       usb_clk,
	input  wire logic                       multi_precision,
	output logic [2:0]                      sys_src_sel,
	output logic                            bus_clk,
	output logic                            cpu_clk,
	output logic [clkdist_pkg::N_DIG-1:0]   dig_clk,
	output logic [clkdist_pkg::N_ANA-1:0]   ana_clk,
	output logic                            usb_use_doubler,
	output logic [1:0]                      doubler_src,
	output logic                            usb_clk_alive
);

	localparam int NS = clkdist_pkg::N_SRC;
	localparam int NF = clkdist_pkg::N_FAB;
	localparam int NP = NS + NF + 1;
	localparam int ND = clkdist_pkg::N_DIV;
	localparam int RW = clkdist_pkg::RATIO_W;
	localparam int CW = clkdist_pkg::DIV_CFG_W;
	localparam int MW = clkdist_pkg::MEAS_W;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [NP-1:0] pin_raw;
	logic [NP-1:0] sync1, sync2, sync3;
	logic [NP-1:0] pin_level, next_pin_level;
	logic [NP-1:0] pin_edge;
	logic [NS-1:0] src_edge;
	logic [NF-1:0] fab_edge;

	assign pin_raw = {usb_clk, fabric_clk, src_clk};

	// A rising edge counts once the second and third stages agree;
	// the first stage is metastability guard only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			pin_level <= '0;
		end else begin
			sync1 <= pin_raw;
			sync2 <= sync1;
			sync3 <= sync2;
			pin_level <= next_pin_level;
		end
	end

	always_comb begin
		// Level only moves when stages two and three agree
		next_pin_level = (sync2 & sync3) | (pin_level & (sync2 | sync3));
		pin_edge = sync2 & sync3 & ~pin_level;
		src_edge = pin_edge[NS-1:0];
		fab_edge = pin_edge[NS+NF-1:NS];
	end

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	logic          wr_pend, next_wr_pend;
	logic [5:0]    wr_word, next_wr_word;
	logic          wr_ok, next_wr_ok;
	logic [31:0]   next_rdata;
	logic          addr_phase;
	logic [15:0]   bus_ratio, next_bus_ratio;
	logic [2:0]    usb_cfg, next_usb_cfg;
	logic [CW-1:0] div_cfg [ND];
	logic [CW-1:0] next_div_cfg [ND];
	logic [ND-1:0] div_out;
	logic [31:0]   rd_word;
	logic [7:0]    rd_off;
	logic [7:0]    wr_off;

	// Zero wait states: every transfer completes in one data phase
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_phase = hsel && htrans[1] && hready;

	// Read data is chosen in the address phase and registered, so it
	// stands for the whole data phase
	always_comb begin
		rd_off = haddr[7:0];
		rd_word = 32'h0000_0000;
		if (haddr[31:8] != 24'h000000 || haddr[1:0] != 2'h0) begin
			rd_word = 32'h0000_0000;
		end else if (rd_off == clkdist_pkg::OFF_BUS) begin
			rd_word = {16'h0000, bus_ratio};
		end else if (rd_off == clkdist_pkg::OFF_STATUS) begin
			rd_word[2:0] = sys_src_sel;
			rd_word[clkdist_pkg::STAT_BUS_BIT] = bus_clk;
			rd_word[clkdist_pkg::STAT_MULT_BIT] = multi_precision;
		end else if (rd_off == clkdist_pkg::OFF_USB) begin
			rd_word[2:0] = usb_cfg;
			rd_word[clkdist_pkg::USB_ALIVE_BIT] = usb_clk_alive;
		end else if (rd_off >= clkdist_pkg::OFF_DIV0 &&
			rd_off <= clkdist_pkg::OFF_LAST) begin
			rd_word[CW-1:0] = div_cfg[4'(rd_off[5:2] - 4'h4)];
			rd_word[clkdist_pkg::DIV_OUT_BIT] =
				div_out[4'(rd_off[5:2] - 4'h4)];
		end
		next_rdata = (addr_phase && !hwrite) ? rd_word : hrdata;
		next_wr_pend = addr_phase && hwrite;
		next_wr_word = addr_phase ? haddr[7:2] : wr_word;
		next_wr_ok = haddr[31:8] == 24'h000000 && haddr[1:0] == 2'h0;
	end

	// Configuration writes land at the end of the data phase
	always_comb begin
		wr_off = {wr_word, 2'b00};
		next_bus_ratio = bus_ratio;
		next_usb_cfg = usb_cfg;
		for (int i = 0; i < ND; i++) begin
			next_div_cfg[i] = div_cfg[i];
		end
		if (wr_pend && wr_ok) begin
			if (wr_off == clkdist_pkg::OFF_BUS) begin
				next_bus_ratio = hwdata[15:0];
			end else if (wr_off == clkdist_pkg::OFF_USB) begin
				next_usb_cfg = hwdata[2:0];
			end else if (wr_off >= clkdist_pkg::OFF_DIV0 &&
				wr_off <= clkdist_pkg::OFF_LAST) begin
				next_div_cfg[4'(wr_word[3:0] - 4'h4)] = hwdata[CW-1:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_word <= 6'h00;
			wr_ok <= 1'b0;
			hrdata <= 32'h0000_0000;
			bus_ratio <= clkdist_pkg::BUS_RATIO_RST;
			usb_cfg <= clkdist_pkg::USB_CFG_RST;
			for (int i = 0; i < ND; i++) begin
				div_cfg[i] <= clkdist_pkg::DIV_CFG_RST;
			end
		end else begin
			wr_pend <= next_wr_pend;
			wr_word <= next_wr_word;
			wr_ok <= next_wr_ok;
			hrdata <= next_rdata;
			bus_ratio <= next_bus_ratio;
			usb_cfg <= next_usb_cfg;
			for (int i = 0; i < ND; i++) begin
				div_cfg[i] <= next_div_cfg[i];
			end
		end
	end

	// A bus ratio write shows on the register one edge after its
	// data phase
	sequence s_bus_write;
		wr_pend && wr_ok && (wr_off == clkdist_pkg::OFF_BUS);
	endsequence

	a_bus_write: assert property (@(posedge hclk) disable iff (!hresetn)
		s_bus_write |=> bus_ratio == $past(hwdata[15:0]))
		else $error("bus ratio write lost");

	// ----------------------------------------------------------------
	// Fastest source detection
	// ----------------------------------------------------------------
	logic [MW-1:0] meas_cnt [NS];
	logic [MW-1:0] next_meas_cnt [NS];
	logic [MW-1:0] win, next_win;
	logic [2:0]    next_sys_sel;
	logic [MW-1:0] best;
	logic          meas_end;

	// Edges of every source are counted over a fixed window and the
	// busiest one wins; a stopped source simply scores zero
	always_comb begin
		meas_end = win == MW'(clkdist_pkg::MEAS_CYC - 1);
		next_win = win + MW'(1);
		best = '0;
		next_sys_sel = sys_src_sel;
		for (int i = 0; i < NS; i++) begin
			next_meas_cnt[i] = meas_end ? '0 :
				meas_cnt[i] + MW'(src_edge[i]);
			if (meas_end && meas_cnt[i] > best) begin
				best = meas_cnt[i];
				next_sys_sel = 3'(i);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			win <= '0;
			sys_src_sel <= clkdist_pkg::SRC_INTERNAL_MAIN_OSCILLATOR;
			for (int i = 0; i < NS; i++) begin
				meas_cnt[i] <= '0;
			end
		end else begin
			win <= next_win;
			sys_src_sel <= next_sys_sel;
			for (int i = 0; i < NS; i++) begin
				meas_cnt[i] <= next_meas_cnt[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// Bus and processor clock
	// ----------------------------------------------------------------
	clk_divider #(
		.RATIO_W  (RW),
		.SEL_W    (clkdist_pkg::SEL_W),
		.SKEW_W   (clkdist_pkg::SKEW_W),
		.HAS_SKEW (1'b0)
	) u_bus_div (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.src_edge ({1'b0, src_edge}),
		.ratio    (bus_ratio),
		.sel      (sys_src_sel),
		.en       (1'b1),
		.skew     (4'h0),
		.clk_out  (bus_clk),
		.tick     ()
	);

	// The processor shares the bus clock net itself
	assign cpu_clk = bus_clk;

	// ----------------------------------------------------------------
	// General dividers
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < ND; g++) begin : gen_div
			logic [clkdist_pkg::N_MUX-1:0] mux_in;
			logic [clkdist_pkg::FAB_W-1:0] fab_idx;
			logic                          fab_pick;

			assign fab_idx = div_cfg[g][clkdist_pkg::DIV_FAB_LSB +:
				clkdist_pkg::FAB_W];
			// Digital trees only see the fabric when timing is trusted
			assign fab_pick = (g >= clkdist_pkg::N_DIG || multi_precision)
				&& fab_edge[fab_idx];
			assign mux_in = {fab_pick, src_edge};

			clk_divider #(
				.RATIO_W  (RW),
				.SEL_W    (clkdist_pkg::SEL_W),
				.SKEW_W   (clkdist_pkg::SKEW_W),
				.HAS_SKEW (g >= clkdist_pkg::N_DIG)
			) u_div (
				.hclk     (hclk),
				.hresetn  (hresetn),
				.src_edge (mux_in),
				.ratio    (div_cfg[g][clkdist_pkg::DIV_RATIO_LSB +: RW]),
				.sel      (div_cfg[g][clkdist_pkg::DIV_SEL_LSB +:
					clkdist_pkg::SEL_W]),
				.en       (div_cfg[g][clkdist_pkg::DIV_EN_BIT]),
				.skew     (div_cfg[g][clkdist_pkg::DIV_SKEW_LSB +:
					clkdist_pkg::SKEW_W]),
				.clk_out  (div_out[g]),
				.tick     ()
			);
		end
	endgenerate

	// Digital trees go out to the fabric; analog trees follow them
	assign dig_clk = div_out[clkdist_pkg::N_DIG-1:0];
	assign ana_clk = div_out[ND-1:clkdist_pkg::N_DIG];

	// ----------------------------------------------------------------
	// USB clock source
	// ----------------------------------------------------------------
	// The 48 MHz clock is only watched through the pin synchroniser
	usb_clk_source u_usb (
		.hclk            (hclk),
		.hresetn         (hresetn),
		.cfg_use_doubler (usb_cfg[clkdist_pkg::USB_DBL_BIT]),
		.cfg_dbl_src     (usb_cfg[clkdist_pkg::USB_DIN_LSB +: 2]),
		.usb_edge        (pin_edge[NP-1]),
		.use_doubler     (usb_use_doubler),
		.doubler_src     (doubler_src),
		.alive           (usb_clk_alive)
	);

endmodule : clock_distribution

// >>> sim/clock_sources.sv
`timescale 1ns/1ps

module clock_sources #(
	parameter logic [6:0][15:0] SRC_NS = '0,
	parameter logic [7:0][15:0] FAB_NS = '0
) (
	input  wire logic       usb_run,
	output logic [6:0]      src_clk,
	output logic [7:0]      fabric_clk,
	output logic            usb_clk
);
	// ----------------------------------------------------------------
	// Free running primary and fabric clocks, phases staggered so no two primary edges line up
	// ----------------------------------------------------------------
	for (genvar i = 0; i < 7; i++) begin : g_src
		initial begin
			src_clk[i] = 1'b0;
			#(i * 7 + 3);
			forever #(SRC_NS[i] / 2.0) src_clk[i] = ~src_clk[i];
		end
	end
	// Extra fabric clocks for divider inputs
	for (genvar i = 0; i < 8; i++) begin : g_fab
		initial begin
			fabric_clk[i] = 1'b0;
			#(i * 5 + 11);
			forever #(FAB_NS[i] / 2.0) fabric_clk[i] = ~fabric_clk[i];
		end
	end
	// 48 MHz clock, unrelated in phase; stands low while stopped
	initial begin
		usb_clk = 1'b0;
		#1.3;
		forever begin
			if (usb_run) begin
				#10.417 usb_clk = ~usb_clk;
			end else begin
				usb_clk = 1'b0;
				@(posedge usb_run);
			end
		end
	end
endmodule : clock_sources

// >>> sim/testbench.sv
`timescale 1ns/1ps

module testbench;
	// ----------------------------------------------------------------
	// Stimulus set-up
	// ----------------------------------------------------------------
	// Source 3 is the fastest, so it must become the system clock
	localparam logic [6:0][15:0] SRC_NS = {16'h015e, 16'h0190, 16'h012c,
		16'h0064, 16'h00c8, 16'h00fa, 16'h0096};
	localparam logic [7:0][15:0] FAB_NS = {16'h012c, 16'h0113, 16'h00fa,
		16'h00e1, 16'h00c8, 16'h00af, 16'h0096, 16'h007d};
	localparam int WIN   = 1200;
	localparam int LIMIT = 40000;

	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans, doubler_src;
	logic [2:0]  hsize, sys_src_sel;
	logic [6:0]  src_clk;
	logic [7:0]  fabric_clk, dig_clk;
	logic [3:0]  ana_clk;
	logic        usb_clk, usb_run, multi_precision, bus_clk, cpu_clk;
	logic        usb_use_doubler, usb_clk_alive;
	int          fail_count, num_checks, cycles;

	clock_distribution uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .src_clk(src_clk),
		.fabric_clk(fabric_clk), .usb_clk(usb_clk),
		.multi_precision(multi_precision), .sys_src_sel(sys_src_sel),
		.bus_clk(bus_clk), .cpu_clk(cpu_clk), .dig_clk(dig_clk),
		.ana_clk(ana_clk), .usb_use_doubler(usb_use_doubler),
		.doubler_src(doubler_src), .usb_clk_alive(usb_clk_alive));

	clock_sources #(.SRC_NS(SRC_NS), .FAB_NS(FAB_NS)) sources (
		.usb_run(usb_run), .src_clk(src_clk), .fabric_clk(fabric_clk),
		.usb_clk(usb_clk));

	// Bus clock, 25 ns period
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	task automatic check(input bit ok, input string msg);
		num_checks++;
		if (!ok) begin
			fail_count++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : check

	// Hang guard: a stuck handshake would otherwise never end the run
	always @(posedge hclk) begin
		cycles++;
		if (cycles == LIMIT) begin
			fail_count++;
			conclude();
		end
	end

	// Single word transfer; entered just after a rising edge
	task automatic xfer(input logic [31:0] a, input bit wr,
			input logic [31:0] d, output logic [31:0] q);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= wr;
		htrans <= 2'b10;
		hsize  <= 3'b010;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wr ? d : 32'h0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
		check(hresp === 1'b0, "error response");
	endtask : xfer

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(a, 1'b1, d, q);
	endtask : wr

	function automatic logic [31:0] cfg(int r, int s, int f, int sk, bit en);
		return {4'h0, 4'(sk), 1'b0, 3'(f), en, 3'(s), 16'(r)};
	endfunction : cfg

	function automatic logic pick(int i);
		if (i < 8) return dig_clk[i];
		if (i < 12) return ana_clk[i - 8];
		return bus_clk;
	endfunction : pick

	function automatic bit near(int got, int per, int r);
		int e;
		e = WIN * 25 / (per * r);
		return got >= e - 2 && got <= e + 2;
	endfunction : near

	function automatic bit duty_ok(int hi, int per, int r);
		int d;
		d = 2 * hi - WIN;
		if (d < 0) d = -d;
		return d <= WIN / r + r * per / 25 + 8;
	endfunction : duty_ok

	// Rising edges, high time and shortest whole phase of one output
	task automatic measure(input int i, output int rises, output int hi,
			output int minrun, output int cpu_bad);
		logic v, prev;
		int run;
		bit seen;
		rises = 0; hi = 0; minrun = 100000; cpu_bad = 0; run = 0; seen = 0;
		for (int k = 0; k < WIN; k++) begin
			@(negedge hclk);
			v = pick(i);
			if (k > 0 && v !== prev) begin
				if (seen && run < minrun) minrun = run;
				seen = 1;
				run = 0;
				if (v === 1'b1) rises++;
			end
			run++;
			if (v === 1'b1) hi++;
			if (cpu_clk !== bus_clk) cpu_bad++;
			prev = v;
		end
		@(posedge hclk);
	endtask : measure

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] q, w;
		int ri, hi, mr, cb, s, r, f;
		hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2;
		hwdata = 0; multi_precision = 0; usb_run = 1; hresetn = 0;
		fail_count = 0; num_checks = 0; cycles = 0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		void'($urandom(32'hda1ef187));
		@(posedge hclk);
		// Reset values of every configuration register
		xfer(clkdist_pkg::OFF_BUS, 0, 0, q);
		check(q[15:0] === clkdist_pkg::BUS_RATIO_RST, "bus ratio reset");
		for (int i = 0; i < 12; i++) begin
			xfer(clkdist_pkg::OFF_DIV0 + 4 * i, 0, 0, q);
			check(q[27:0] === clkdist_pkg::DIV_CFG_RST, "divider reset");
		end
		xfer(clkdist_pkg::OFF_USB, 0, 0, q);
		check(q[2:0] === clkdist_pkg::USB_CFG_RST, "usb reset");
		xfer(32'h0000000c, 0, 0, q); // unmapped hole, still OKAY
		// Fastest source found by measurement
		repeat (3 * clkdist_pkg::MEAS_CYC) @(posedge hclk);
		check(sys_src_sel === clkdist_pkg::SRC_PLL, "system source");
		// Bus clock ratios; processor clock follows it exactly
		for (int j = 0; j < 2; j++) begin
			r = (j == 0) ? 2 : 5;
			wr(clkdist_pkg::OFF_BUS, 32'(r));
			repeat (100) @(posedge hclk);
			measure(12, ri, hi, mr, cb);
			check(near(ri, 100, r), "bus clock rate");
			check(cb == 0, "cpu clock differs");
		end
		// Every divider, every source; random ratio except divider 0, random skew on analog dividers only
		for (int n = 0; n < 12; n++) begin
			s = n % 7;
			r = (n == 0) ? 2 : 2 + $urandom % 9;
			w = cfg(r, s, 0, n < 8 ? 0 : $urandom % 16, 1);
			wr(clkdist_pkg::OFF_DIV0 + 4 * n, w);
			xfer(clkdist_pkg::OFF_DIV0 + 4 * n, 0, 0, q);
			check(q[27:0] === w[27:0], "divider readback");
			repeat (200) @(posedge hclk);
			measure(n, ri, hi, mr, cb);
			check(near(ri, SRC_NS[s], r), "divider rate");
			check(duty_ok(hi, SRC_NS[s], r), "divider duty");
		end
		// Disabled divider stays quiet
		wr(clkdist_pkg::OFF_DIV0, cfg(2, 3, 0, 0, 0));
		repeat (50) @(posedge hclk);
		measure(0, ri, hi, mr, cb);
		check(ri == 0, "disabled divider toggles");
		// Fabric input, allowed only with several precise sources
		f = $urandom % 8;
		multi_precision <= 1'b1;
		wr(clkdist_pkg::OFF_DIV0 + 4, cfg(3, 7, f, 0, 1));
		xfer(clkdist_pkg::OFF_STATUS, 0, 0, q);
		check(q[clkdist_pkg::STAT_MULT_BIT] === 1'b1, "status flag");
		repeat (100) @(posedge hclk);
		measure(1, ri, hi, mr, cb);
		check(near(ri, FAB_NS[f], 3), "fabric rate");
		multi_precision <= 1'b0;
		repeat (100) @(posedge hclk);
		measure(1, ri, hi, mr, cb);
		check(ri == 0, "fabric without precision");
		// Ratio change in mid-flight must not shorten a phase
		wr(clkdist_pkg::OFF_DIV0 + 8, cfg(6, 0, 0, 0, 1));
		repeat (100) @(posedge hclk);
		fork
			measure(2, ri, hi, mr, cb);
			begin
				repeat (97) @(posedge hclk);
				wr(clkdist_pkg::OFF_DIV0 + 8, cfg(2, 0, 0, 0, 1));
			end
		join
		check(mr >= 150 / 25 - 1, "short phase");
		// USB clock sourcing and activity detection
		wr(clkdist_pkg::OFF_USB, {29'h0, clkdist_pkg::DIN_XTAL, 1'b0});
		repeat (4) @(posedge hclk);
		check(usb_use_doubler === 1'b0, "doubler on");
		check(doubler_src === clkdist_pkg::DIN_XTAL, "doubler src");
		wr(clkdist_pkg::OFF_USB, {29'h0, clkdist_pkg::DIN_FABRIC, 1'b1});
		repeat (4) @(posedge hclk);
		check(usb_use_doubler === 1'b1, "doubler off");
		check(doubler_src === clkdist_pkg::DIN_FABRIC, "doubler src");
		check(usb_clk_alive === 1'b1, "usb clock unseen");
		usb_run <= 1'b0;
		repeat (2 * clkdist_pkg::USB_ALIVE_CYC + 8) @(posedge hclk);
		check(usb_clk_alive === 1'b0, "stopped usb clock seen");
		usb_run <= 1'b1;
		repeat (2 * clkdist_pkg::USB_ALIVE_CYC + 8) @(posedge hclk);
		check(usb_clk_alive === 1'b1, "usb clock lost");
		conclude();
	end
endmodule : testbench
